// File: rtl/sxle_top.sv
// wishbone register bank enabling extra serial lanes on links a and b
//
// Summary of operation
// - link A bits 7..1 enable lanes 1..7
// - link B register, same layout, resets zero
// - lane bit turns on link-layer clocks only
// - bit 0 also powers extra-lane serializers
// - extra lanes use mode's rate and mode
// - channel power-down always keeps lanes off
// - serializer clocked only if lower lanes on
// - link B bit 0 powers link B serializers only
// - link A register resets to zero
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module sxle_top
    import sxle_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [SXLE_ADR_W-1:0] wb_adr_i,
    input wire logic [SXLE_DAT_W-1:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [SXLE_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serial_link_enable_i,
    input wire logic [SXLE_LANES-1:0] link_a_mode_lanes_i,
    input wire logic [SXLE_LANES-1:0] link_b_mode_lanes_i,
    input wire logic link_a_power_down_i,
    input wire logic link_b_power_down_i,
    output logic [SXLE_LANES-1:0] link_a_lane_clk_on_o,
    output logic [SXLE_LANES-1:0] link_a_ser_power_o,
    output logic [SXLE_LANES-1:0] link_a_ser_clk_on_o,
    output logic [SXLE_LANES-1:0] link_b_lane_clk_on_o,
    output logic [SXLE_LANES-1:0] link_b_ser_power_o,
    output logic [SXLE_LANES-1:0] link_b_ser_clk_on_o
);
    // all state in one record: bus registers, handshake and the registered lane controls
    typedef struct packed {
        logic [SXLE_REG_W-1:0] link_a_extra_lane_enable;
        logic [SXLE_REG_W-1:0] link_b_extra_lane_enable;
        logic ack;
        logic [SXLE_DAT_W-1:0] rdata;
        logic [SXLE_LANES-1:0] a_lane_clk;
        logic [SXLE_LANES-1:0] a_ser_pwr;
        logic [SXLE_LANES-1:0] a_ser_clk;
        logic [SXLE_LANES-1:0] b_lane_clk;
        logic [SXLE_LANES-1:0] b_ser_pwr;
        logic [SXLE_LANES-1:0] b_ser_clk;
    } sxle_state_t;

    // bus index decode result; status is the only read-only target
    typedef enum logic [1:0] {
        SXLE_SEL_NONE,
        SXLE_SEL_LINK_A,
        SXLE_SEL_LINK_B,
        SXLE_SEL_STATUS
    } sxle_sel_t;

    sxle_state_t st;
    sxle_state_t next_st;
    logic [SXLE_LANES-1:0] a_lane_clk_c;
    logic [SXLE_LANES-1:0] a_ser_pwr_c;
    logic [SXLE_LANES-1:0] a_ser_clk_c;
    logic [SXLE_LANES-1:0] b_lane_clk_c;
    logic [SXLE_LANES-1:0] b_ser_pwr_c;
    logic [SXLE_LANES-1:0] b_ser_clk_c;
    logic [SXLE_IDX_W-1:0] idx;
    logic req;
    sxle_sel_t sel;

    // widen a register to a bus word with zero upper bits
    function automatic logic [SXLE_DAT_W-1:0] sxle_zext(input logic [SXLE_REG_W-1:0] v);
        sxle_zext = {{(SXLE_DAT_W-SXLE_REG_W){1'b0}}, v};
    endfunction

    // decoded once so the write and read paths cannot disagree about the map
    function automatic sxle_sel_t sxle_decode(input logic [SXLE_IDX_W-1:0] i);
        sxle_sel_t s;
        s = SXLE_SEL_NONE;
        if (i == SXLE_IDX_LINK_A)
        begin
            s = SXLE_SEL_LINK_A;
        end
        if (i == SXLE_IDX_LINK_B)
        begin
            s = SXLE_SEL_LINK_B;
        end
        if (i == SXLE_IDX_STATUS)
        begin
            s = SXLE_SEL_STATUS;
        end
        sxle_decode = s;
    endfunction

    // power-down is applied inside the gate, so no register value can override it
    sxle_lane_gate u_gate_a (
        .mode_lanes_i(link_a_mode_lanes_i),
        .extra_reg_i(st.link_a_extra_lane_enable),
        .power_down_i(link_a_power_down_i),
        .lane_clk_on_o(a_lane_clk_c),
        .ser_power_o(a_ser_pwr_c),
        .ser_clk_on_o(a_ser_clk_c)
    );

    sxle_lane_gate u_gate_b (
        .mode_lanes_i(link_b_mode_lanes_i),
        .extra_reg_i(st.link_b_extra_lane_enable),
        .power_down_i(link_b_power_down_i),
        .lane_clk_on_o(b_lane_clk_c),
        .ser_power_o(b_ser_pwr_c),
        .ser_clk_on_o(b_ser_clk_c)
    );

    // map, one 8-bit register (16 bits for status) per 32-bit word with the upper bits reading zero:
    //   index 0x20A link a extra lanes, index 0x20B link b extra lanes,
    //   index 0x20C read-only serializer clock status, link a in [7:0], link b in [15:8];
    //   any other index is acked, drops writes and reads zero
    // the two low address bits pick a byte inside the word and are ignored
    assign idx = wb_adr_i[SXLE_ADR_W-1:2];
    assign sel = sxle_decode(idx);
    // one wait state: ack drops the cycle after it was given
    assign req = wb_cyc_i & wb_stb_i & ~st.ack;

    always_comb
    begin
        next_st = st;
        next_st.ack = req;
        next_st.rdata = SXLE_DAT_ZERO;

        // writes are not blocked while the link runs; software keeps it disabled first
        if (req && wb_we_i && wb_sel_i[0])
        begin
            unique case (sel)
                SXLE_SEL_LINK_A:
                begin
                    next_st.link_a_extra_lane_enable = wb_dat_i[SXLE_REG_W-1:0];
                end
                SXLE_SEL_LINK_B:
                begin
                    next_st.link_b_extra_lane_enable = wb_dat_i[SXLE_REG_W-1:0];
                end
                SXLE_SEL_STATUS, SXLE_SEL_NONE:
                begin
                    // status is read-only and unmapped words hold nothing, so the write is dropped
                    next_st.link_a_extra_lane_enable = st.link_a_extra_lane_enable;
                end
            endcase
        end

        // read data stands only in the ack cycle and is zero otherwise
        if (req && !wb_we_i)
        begin
            unique case (sel)
                SXLE_SEL_LINK_A:
                begin
                    next_st.rdata = sxle_zext(st.link_a_extra_lane_enable);
                end
                SXLE_SEL_LINK_B:
                begin
                    next_st.rdata = sxle_zext(st.link_b_extra_lane_enable);
                end
                SXLE_SEL_STATUS:
                begin
                    next_st.rdata[SXLE_STAT_A_LSB +: SXLE_LANES] = st.a_ser_clk;
                    next_st.rdata[SXLE_STAT_B_LSB +: SXLE_LANES] = st.b_ser_clk;
                end
                SXLE_SEL_NONE:
                begin
                    next_st.rdata = SXLE_DAT_ZERO;
                end
            endcase
        end

        // lane controls are registered, so they follow a register write one clock later
        next_st.a_lane_clk = a_lane_clk_c;
        next_st.a_ser_pwr = a_ser_pwr_c;
        next_st.a_ser_clk = a_ser_clk_c;
        next_st.b_lane_clk = b_lane_clk_c;
        next_st.b_ser_pwr = b_ser_pwr_c;
        next_st.b_ser_clk = b_ser_clk_c;

        // reset also clears the registered lane controls: nothing extra runs until software writes
        if (rst_i)
        begin
            next_st.link_a_extra_lane_enable = SXLE_LINK_A_RESET;
            next_st.link_b_extra_lane_enable = SXLE_LINK_B_RESET;
            next_st.ack = 1'b0;
            next_st.rdata = SXLE_DAT_ZERO;
            next_st.a_lane_clk = SXLE_LANES_OFF;
            next_st.a_ser_pwr = SXLE_LANES_OFF;
            next_st.a_ser_clk = SXLE_LANES_OFF;
            next_st.b_lane_clk = SXLE_LANES_OFF;
            next_st.b_ser_pwr = SXLE_LANES_OFF;
            next_st.b_ser_clk = SXLE_LANES_OFF;
        end
    end

    // synchronous reset is folded into next_st, so one register stage carries all state
    always_ff @(posedge clk_i)
    begin
        st <= next_st;
    end

    // every output is a register bit of st
    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign link_a_lane_clk_on_o = st.a_lane_clk;
    assign link_a_ser_power_o = st.a_ser_pwr;
    assign link_a_ser_clk_on_o = st.a_ser_clk;
    assign link_b_lane_clk_on_o = st.b_lane_clk;
    assign link_b_ser_power_o = st.b_ser_pwr;
    assign link_b_ser_clk_on_o = st.b_ser_clk;

    // serial_link_enable_i is informational; no gating depends on it
    logic unused_enable;
    assign unused_enable = serial_link_enable_i;
endmodule
`default_nettype wire

// File: rtl/sxle_pkg.sv
// constants and register layout for the serial extra lane enable bank
package sxle_pkg;
    localparam int unsigned SXLE_ADR_W = 12;
    localparam int unsigned SXLE_DAT_W = 32;
    localparam int unsigned SXLE_IDX_W = 10;
    localparam int unsigned SXLE_LANES = 8;
    localparam int unsigned SXLE_REG_W = 8;
    // register indices; byte address is four times the index
    localparam logic [SXLE_IDX_W-1:0] SXLE_IDX_LINK_A = 10'h20A;
    localparam logic [SXLE_IDX_W-1:0] SXLE_IDX_LINK_B = 10'h20B;
    localparam logic [SXLE_IDX_W-1:0] SXLE_IDX_STATUS = 10'h20C;
    localparam logic [SXLE_REG_W-1:0] SXLE_LINK_A_RESET = 8'h00;
    localparam logic [SXLE_REG_W-1:0] SXLE_LINK_B_RESET = 8'h00;
    localparam int unsigned SXLE_SER_BIT = 0;
    localparam int unsigned SXLE_LANE_LSB = 1;
    localparam int unsigned SXLE_LANE_MSB = 7;
    localparam int unsigned SXLE_STAT_A_LSB = 0;
    localparam int unsigned SXLE_STAT_B_LSB = 8;
    localparam logic [SXLE_DAT_W-1:0] SXLE_DAT_ZERO = 32'h0000_0000;
    localparam logic [SXLE_LANES-1:0] SXLE_LANES_OFF = 8'h00;
endpackage

// File: rtl/sxle_lane_gate.sv
// per-link combination of mode lanes, extra lanes and power-down
`timescale 1ns/1ns
`default_nettype none
module sxle_lane_gate
    import sxle_pkg::*;
(
    input wire logic [SXLE_LANES-1:0] mode_lanes_i,
    input wire logic [SXLE_REG_W-1:0] extra_reg_i,
    input wire logic power_down_i,
    output logic [SXLE_LANES-1:0] lane_clk_on_o,
    output logic [SXLE_LANES-1:0] ser_power_o,
    output logic [SXLE_LANES-1:0] ser_clk_on_o
);
    logic [SXLE_LANES-1:0] extra_lanes;
    logic lower_all_on;

    always_comb
    begin
        lower_all_on = 1'b1;
        // bit 0 is the serializer select, so lane 0 is never an extra lane
        extra_lanes = {extra_reg_i[SXLE_LANE_MSB:SXLE_LANE_LSB], 1'b0};
        // extra lanes add clocks, and serializer power only when bit 0 is set; rate and mode still come from the mode lanes' settings
        lane_clk_on_o = mode_lanes_i | extra_lanes;
        ser_power_o = mode_lanes_i;
        if (extra_reg_i[SXLE_SER_BIT])
        begin
            ser_power_o = mode_lanes_i | extra_lanes;
        end
        if (power_down_i)
        begin
            lane_clk_on_o = SXLE_LANES_OFF;
            ser_power_o = SXLE_LANES_OFF;
        end
        // a serializer gets its clock only behind an unbroken run of lower lanes
        for (int n = 0; n < SXLE_LANES; n++)
        begin
            ser_clk_on_o[n] = ser_power_o[n] & lower_all_on;
            lower_all_on = lower_all_on & lane_clk_on_o[n];
        end
    end
endmodule
`default_nettype wire

// File: bench/sxle_assertions.sv
// concurrent checks on the extra lane enable bank ports
`timescale 1ns/1ns
`default_nettype none
module sxle_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic link_a_power_down_i,
    input wire logic link_b_power_down_i,
    input wire logic [7:0] link_a_lane_clk_on_o,
    input wire logic [7:0] link_a_ser_power_o,
    input wire logic [7:0] link_a_ser_clk_on_o,
    input wire logic [7:0] link_b_lane_clk_on_o,
    input wire logic [7:0] link_b_ser_power_o,
    input wire logic [7:0] link_b_ser_clk_on_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a serializer gets no clock unless every lower lane clock runs
    function automatic logic [7:0] chain(input logic [7:0] p, input logic [7:0] c);
        logic a;
        a = 1'b1;
        for (int n = 0; n < 8; n++)
        begin
            chain[n] = p[n] & a;
            a = a & c[n];
        end
    endfunction
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not one pulse");
    property p_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_idle: assert property (p_idle) else $error("read data outside ack");
    property p_pd_a;
        link_a_power_down_i |=> (link_a_lane_clk_on_o | link_a_ser_power_o) == 8'h00;
    endproperty
    a_pd_a: assert property (p_pd_a) else $error("link a lanes on in power down");
    property p_pd_b;
        link_b_power_down_i |=> (link_b_lane_clk_on_o | link_b_ser_power_o) == 8'h00;
    endproperty
    a_pd_b: assert property (p_pd_b) else $error("link b lanes on in power down");
    property p_sub;
        ((link_a_ser_power_o & ~link_a_lane_clk_on_o) | (link_b_ser_power_o & ~link_b_lane_clk_on_o)) == 8'h00;
    endproperty
    a_sub: assert property (p_sub) else $error("serializer powered without lane clock");
    property p_chain_a;
        link_a_ser_clk_on_o == chain(link_a_ser_power_o, link_a_lane_clk_on_o);
    endproperty
    a_chain_a: assert property (p_chain_a) else $error("link a serializer clock chain");
    property p_chain_b;
        link_b_ser_clk_on_o == chain(link_b_ser_power_o, link_b_lane_clk_on_o);
    endproperty
    a_chain_b: assert property (p_chain_b) else $error("link b serializer clock chain");
    property p_rst;
        disable iff (1'b0) rst_i |=> (link_a_lane_clk_on_o | link_b_lane_clk_on_o) == 8'h00 && !wb_ack_o;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule
bind sxle_top sxle_assertions u_chk (.*);
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the extra lane enable bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sxle_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, we = 1'b0, ack, pd_a = 1'b0, pd_b = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0, rdat;
    logic [47:0] rd;
    logic [3:0] sel = 4'h0;
    logic [7:0] ma = 8'h01, mb = 8'h00, lca, spa, sca, lcb, spb, scb;
    int bad_count = 0, n_checks = 0, cycles = 0;
    always #5 clk_i = ~clk_i;
    sxle_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .serial_link_enable_i(1'b0), .link_a_mode_lanes_i(ma), .link_b_mode_lanes_i(mb),
        .link_a_power_down_i(pd_a), .link_b_power_down_i(pd_b), .link_a_lane_clk_on_o(lca),
        .link_a_ser_power_o(spa), .link_a_ser_clk_on_o(sca), .link_b_lane_clk_on_o(lcb),
        .link_b_ser_power_o(spb), .link_b_ser_clk_on_o(scb));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // link enable stays low throughout, so every write here is legal
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, input logic s);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        sel <= {3'h0, s};
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = {16'h0000, rdat};
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic outs(input logic [47:0] exp);
        chk({lca, spa, sca, lcb, spb, scb}, exp);
    endtask
    task automatic t_reset;
        outs(48'h010101_000000);
        bus(1'b0, 12'h828, 8'h00, 1'b1);
        chk(rd, 48'h0);
        bus(1'b0, 12'h82C, 8'h00, 1'b1);
        chk(rd, 48'h0);
    endtask
    task automatic t_link_a;
        bus(1'b1, 12'h828, 8'hFE, 1'b1);
        outs(48'hFF0101_000000);
        bus(1'b1, 12'h828, 8'hFF, 1'b1);
        outs(48'hFFFFFF_000000);
        bus(1'b1, 12'h828, 8'h0B, 1'b1);
        outs(48'h0B0B03_000000);
        bus(1'b0, 12'h828, 8'h00, 1'b1);
        chk(rd, 48'h0B);
    endtask
    task automatic t_link_b;
        bus(1'b1, 12'h82C, 8'h07, 1'b1);
        outs(48'h0B0B03_060600);
        mb <= 8'h01;
        repeat (2) @(posedge clk_i);
        outs(48'h0B0B03_070707);
        bus(1'b0, 12'h830, 8'h00, 1'b1);
        chk(rd, 48'h0703);
        bus(1'b1, 12'h82C, 8'h06, 1'b1);
        outs(48'h0B0B03_070101);
    endtask
    task automatic t_refuse;
        bus(1'b1, 12'h828, 8'hFF, 1'b0);
        bus(1'b1, 12'h900, 8'hFF, 1'b1);
        bus(1'b0, 12'h828, 8'h00, 1'b1);
        chk(rd, 48'h0B);
        bus(1'b0, 12'h900, 8'h00, 1'b1);
        chk(rd, 48'h0);
        // status is read-only: a write there must leave both links as they were
        bus(1'b1, 12'h830, 8'hFF, 1'b1);
        bus(1'b0, 12'h830, 8'h00, 1'b1);
        chk(rd, 48'h0103);
    endtask
    task automatic t_power_down;
        pd_a <= 1'b1;
        pd_b <= 1'b1;
        repeat (2) @(posedge clk_i);
        outs(48'h0);
        pd_a <= 1'b0;
        pd_b <= 1'b0;
        repeat (2) @(posedge clk_i);
        outs(48'h0B0B03_070101);
    endtask
    // a second reset with both registers set must clear them and every extra lane
    task automatic t_rerun;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        outs(48'h0);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        outs(48'h010101_010101);
        bus(1'b0, 12'h828, 8'h00, 1'b1);
        chk(rd, 48'h0);
        bus(1'b0, 12'h82C, 8'h00, 1'b1);
        chk(rd, 48'h0);
    endtask
    task automatic end_sim;
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            bad_count++;
            end_sim();
        end
    end
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_reset();
        t_link_a();
        t_link_b();
        t_refuse();
        t_power_down();
        t_rerun();
        end_sim();
    end
endmodule
`default_nettype wire
